// ---- ohfr_map.vh ----
`ifndef OHFR_MAP_VH
`define OHFR_MAP_VH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define OHFR_OFF_VERSION 8'h00
`define OHFR_OFF_ROM 8'h04
`define OHFR_OFF_RETRY 8'h08
`define OHFR_OFF_SWAP_DATA 8'h0c
`define OHFR_OFF_SWAP_CMP 8'h10
`define OHFR_OFF_SWAP_CTRL 8'h14

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define OHFR_VER_PRESENT_BIT 24
`define OHFR_VER_MAJOR_HI 23
`define OHFR_VER_MAJOR_LO 16
`define OHFR_VER_MINOR_HI 7
`define OHFR_VER_MINOR_LO 0
`define OHFR_ROM_CLEAR_BIT 31
`define OHFR_ROM_GO_BIT 25
`define OHFR_ROM_DATA_HI 23
`define OHFR_ROM_DATA_LO 16
`define OHFR_ROM_BOOT_HI 7
`define OHFR_ROM_BOOT_LO 0
`define OHFR_RTY_PHYS_HI 11
`define OHFR_RTY_PHYS_LO 8
`define OHFR_RTY_RESP_HI 7
`define OHFR_RTY_RESP_LO 4
`define OHFR_RTY_REQ_HI 3
`define OHFR_RTY_REQ_LO 0
`define OHFR_SWC_DONE_BIT 31
`define OHFR_SWC_SEL_HI 1
`define OHFR_SWC_SEL_LO 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define OHFR_VER_MAJOR_RST 8'h01
`define OHFR_VER_MINOR_RST 8'h00
`define OHFR_RETRY_RST 12'h000
`define OHFR_SWC_DONE_RST 1'b1
`define OHFR_SWC_SEL_RST 2'h0
`define OHFR_WORD_RST 32'h00000000

// ----------------------------------------------------------------
// swap targets
// ----------------------------------------------------------------
`define OHFR_SEL_BUS_MANAGER_ID 2'h0
`define OHFR_SEL_BANDWIDTH 2'h1
`define OHFR_SEL_CHANNELS_HI 2'h2
`define OHFR_SEL_CHANNELS_LO 2'h3

`endif

// ---- ohfr_csr_swap.v ----
`timescale 1ns/1ps
`include "ohfr_map.vh"

module ohfr_csr_swap #(
  parameter [31:0] BUS_MANAGER_ID_RST = 32'h0000003f,
  parameter [31:0] BANDWIDTH_RST = 32'h00001333,
  parameter [31:0] CHANNELS_HI_RST = 32'hffffffff,
  parameter [31:0] CHANNELS_LO_RST = 32'hffffffff
) (
  input wire ref_clk,
  input wire rst_n,
  input wire host_req,
  input wire [1:0] host_sel,
  input wire [31:0] host_expected,
  input wire [31:0] host_new,
  output reg host_done,
  output reg [31:0] host_old,
  input wire lnk_req,
  input wire [1:0] lnk_sel,
  input wire [31:0] lnk_expected,
  input wire [31:0] lnk_new,
  output reg lnk_ack,
  output reg [31:0] lnk_old
);

  reg [31:0] res_q [0:3];
  wire take_lnk;
  wire [1:0] sel;
  wire [31:0] expected;
  wire [31:0] new_value;
  integer i;

  // ----------------------------------------------------------------
  // one operation per cycle, host first: never interleaved
  // ----------------------------------------------------------------
  assign take_lnk = lnk_req & ~host_req;
  assign sel = take_lnk ? lnk_sel : host_sel;
  assign expected = take_lnk ? lnk_expected : host_expected;
  assign new_value = take_lnk ? lnk_new : host_new;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      res_q[0] <= BUS_MANAGER_ID_RST;
      res_q[1] <= BANDWIDTH_RST;
      res_q[2] <= CHANNELS_HI_RST;
      res_q[3] <= CHANNELS_LO_RST;
      host_done <= 1'b0;
      lnk_ack <= 1'b0;
      host_old <= `OHFR_WORD_RST;
      lnk_old <= `OHFR_WORD_RST;
    end else begin
      host_done <= host_req;
      lnk_ack <= take_lnk;
      if (host_req) begin
        host_old <= res_q[sel];
      end
      if (take_lnk) begin
        lnk_old <= res_q[sel];
      end
      for (i = 0; i < 4; i = i + 1) begin
        if ((host_req | lnk_req) && sel == i[1:0] && res_q[i] == expected) begin
          res_q[i] <= new_value;
        end
      end
    end
  end

endmodule

// ---- ohfr_front_regs.v ----
// Notes on behaviour
// - version reads 01h.00h out of reset
// - eeprom may load version; host cannot
// - present flag bit 24 follows eeprom detection
// - pointer clear zeroes address, self clears
// - read go fetches byte, self clears
// - fetched byte in 23:16, valid when idle
// - bits 7:0 give boot image start
// - rom access reserved bits read zero
// - dual phase retry fields read zero
// - physical response retries bounded by 11:8
// - dma retries bounded by 7:4, 3:0
// - control write starts swap, reports finish
// - control write clears complete flag, unless a swap finishes that cycle
// - select 00..11 picks four bus resources
// - control bits 30:2 read zero
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "ohfr_map.vh"

module ohfr_front_regs #(
  parameter ADDR_W = 8,
  parameter [31:0] BUS_MANAGER_ID_RST = 32'h0000003f,
  parameter [31:0] BANDWIDTH_RST = 32'h00001333,
  parameter [31:0] CHANNELS_HI_RST = 32'hffffffff,
  parameter [31:0] CHANNELS_LO_RST = 32'hffffffff
) (
  input wire ref_clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire eeprom_present,
  input wire ver_load,
  input wire [7:0] ver_load_major,
  input wire [7:0] ver_load_minor,
  input wire [7:0] boot_image_start_in,
  output wire rom_fetch_req,
  output wire [7:0] rom_fetch_addr,
  input wire rom_fetch_ack,
  input wire [7:0] rom_fetch_data,
  output wire [3:0] phys_response_retry_max,
  output wire [3:0] dma_response_retry_max,
  output wire [3:0] dma_request_retry_max,
  input wire lnk_swap_req,
  input wire [1:0] lnk_swap_sel,
  input wire [31:0] lnk_swap_expected,
  input wire [31:0] lnk_swap_new,
  output wire lnk_swap_ack,
  output wire [31:0] lnk_swap_old
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [7:0] ver_major_q;
  reg [7:0] ver_minor_q;
  reg eeprom_present_flag_q;
  reg [7:0] boot_image_start_q;
  reg rom_pointer_clear_q;
  reg rom_read_go_q;
  reg [7:0] rom_addr_q;
  reg [7:0] rom_fetched_byte_q;
  reg [3:0] phys_response_retry_max_q;
  reg [3:0] dma_response_retry_max_q;
  reg [3:0] dma_request_retry_max_q;
  reg [31:0] swap_new_value_q;
  reg [31:0] swap_expected_value_q;
  reg [1:0] swap_target_select_q;
  reg swap_complete_q;
  reg swap_start_q;
  reg rom_state_q;
  reg rom_state_d;
  reg rom_req_now;
  reg [31:0] rd_d;
  wire setup_ph;
  wire wr_acc;
  wire wr_rom;
  wire wr_retry;
  wire wr_data;
  wire wr_cmp;
  wire wr_ctrl;
  wire swap_done;
  wire [31:0] swap_old;
  wire rom_clear_done;

  localparam ROM_IDLE = 1'b0;
  localparam ROM_BUSY = 1'b1;
  localparam [11:0] RETRY_RST = `OHFR_RETRY_RST;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function hit;
    input [ADDR_W-1:0] addr;
    input [7:0] offset;
    begin
      hit = (addr == {{(ADDR_W-8){1'b0}}, offset});
    end
  endfunction

  function mapped;
    input [ADDR_W-1:0] addr;
    begin
      mapped = hit(addr, `OHFR_OFF_VERSION) | hit(addr, `OHFR_OFF_ROM) |
               hit(addr, `OHFR_OFF_RETRY) | hit(addr, `OHFR_OFF_SWAP_DATA) |
               hit(addr, `OHFR_OFF_SWAP_CMP) | hit(addr, `OHFR_OFF_SWAP_CTRL);
    end
  endfunction

  assign setup_ph = psel & ~penable;
  assign pready = psel & penable;
  assign wr_acc = psel & penable & pwrite & mapped(paddr);
  assign wr_rom = wr_acc & hit(paddr, `OHFR_OFF_ROM);
  assign wr_retry = wr_acc & hit(paddr, `OHFR_OFF_RETRY);
  assign wr_data = wr_acc & hit(paddr, `OHFR_OFF_SWAP_DATA);
  assign wr_cmp = wr_acc & hit(paddr, `OHFR_OFF_SWAP_CMP);
  assign wr_ctrl = wr_acc & hit(paddr, `OHFR_OFF_SWAP_CTRL);

  // ----------------------------------------------------------------
  // read mux, sampled in the setup phase
  // ----------------------------------------------------------------
  always @* begin
    rd_d = `OHFR_WORD_RST;
    if (hit(paddr, `OHFR_OFF_VERSION)) begin
      rd_d[`OHFR_VER_PRESENT_BIT] = eeprom_present_flag_q;
      rd_d[`OHFR_VER_MAJOR_HI:`OHFR_VER_MAJOR_LO] = ver_major_q;
      rd_d[`OHFR_VER_MINOR_HI:`OHFR_VER_MINOR_LO] = ver_minor_q;
    end else if (hit(paddr, `OHFR_OFF_ROM)) begin
      rd_d[`OHFR_ROM_CLEAR_BIT] = rom_pointer_clear_q;
      rd_d[`OHFR_ROM_GO_BIT] = rom_read_go_q;
      rd_d[`OHFR_ROM_DATA_HI:`OHFR_ROM_DATA_LO] = rom_fetched_byte_q;
      rd_d[`OHFR_ROM_BOOT_HI:`OHFR_ROM_BOOT_LO] = boot_image_start_q;
    end else if (hit(paddr, `OHFR_OFF_RETRY)) begin
      rd_d[`OHFR_RTY_PHYS_HI:`OHFR_RTY_PHYS_LO] = phys_response_retry_max_q;
      rd_d[`OHFR_RTY_RESP_HI:`OHFR_RTY_RESP_LO] = dma_response_retry_max_q;
      rd_d[`OHFR_RTY_REQ_HI:`OHFR_RTY_REQ_LO] = dma_request_retry_max_q;
    end else if (hit(paddr, `OHFR_OFF_SWAP_DATA)) begin
      rd_d = swap_new_value_q;
    end else if (hit(paddr, `OHFR_OFF_SWAP_CMP)) begin
      rd_d = swap_expected_value_q;
    end else if (hit(paddr, `OHFR_OFF_SWAP_CTRL)) begin
      rd_d[`OHFR_SWC_DONE_BIT] = swap_complete_q;
      rd_d[`OHFR_SWC_SEL_HI:`OHFR_SWC_SEL_LO] = swap_target_select_q;
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= `OHFR_WORD_RST;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      prdata <= pwrite ? `OHFR_WORD_RST : rd_d;
      pslverr <= ~mapped(paddr);
    end
  end

  // ----------------------------------------------------------------
  // version register
  // ----------------------------------------------------------------
  // reset to level 1.0
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ver_major_q <= `OHFR_VER_MAJOR_RST;
      ver_minor_q <= `OHFR_VER_MINOR_RST;
    end else if (ver_load) begin
      ver_major_q <= ver_load_major;
      ver_minor_q <= ver_load_minor;
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      eeprom_present_flag_q <= 1'b0;
      boot_image_start_q <= 8'h00;
    end else begin
      eeprom_present_flag_q <= eeprom_present;
      boot_image_start_q <= eeprom_present ? boot_image_start_in : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // serial rom access
  // ----------------------------------------------------------------
  // fetch holds its request
  always @* begin
    rom_state_d = rom_state_q;
    rom_req_now = 1'b0;
    case (rom_state_q)
      ROM_IDLE: begin
        rom_req_now = rom_read_go_q & ~rom_pointer_clear_q;
        if (rom_req_now && !rom_fetch_ack) begin
          rom_state_d = ROM_BUSY;
        end
      end
      ROM_BUSY: begin
        rom_req_now = 1'b1;
        if (rom_fetch_ack) begin
          rom_state_d = ROM_IDLE;
        end
      end
      default: begin
        rom_state_d = ROM_IDLE;
      end
    endcase
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rom_state_q <= ROM_IDLE;
    end else begin
      rom_state_q <= rom_state_d;
    end
  end

  assign rom_fetch_req = rom_req_now;
  assign rom_fetch_addr = rom_addr_q;
  assign rom_clear_done = rom_pointer_clear_q & ~rom_req_now;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rom_pointer_clear_q <= 1'b0;
      rom_read_go_q <= 1'b0;
      rom_addr_q <= 8'h00;
      rom_fetched_byte_q <= 8'h00;
    end else begin
      if (wr_rom && pwdata[`OHFR_ROM_CLEAR_BIT]) begin
        rom_pointer_clear_q <= 1'b1;
      end else if (rom_clear_done) begin
        rom_pointer_clear_q <= 1'b0;
      end
      if (rom_clear_done) begin
        rom_addr_q <= 8'h00;
      end else if (rom_fetch_req && rom_fetch_ack) begin
        rom_addr_q <= rom_addr_q + 8'h01;
      end
      if (wr_rom && pwdata[`OHFR_ROM_GO_BIT]) begin
        rom_read_go_q <= 1'b1;
      end else if (rom_fetch_req && rom_fetch_ack) begin
        rom_read_go_q <= 1'b0;
      end
      if (rom_fetch_req && rom_fetch_ack) begin
        rom_fetched_byte_q <= rom_fetch_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // retry limits
  // ----------------------------------------------------------------
  // physical response and dma retry bounds
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phys_response_retry_max_q <= RETRY_RST[`OHFR_RTY_PHYS_HI:`OHFR_RTY_PHYS_LO];
      dma_response_retry_max_q <= RETRY_RST[`OHFR_RTY_RESP_HI:`OHFR_RTY_RESP_LO];
      dma_request_retry_max_q <= RETRY_RST[`OHFR_RTY_REQ_HI:`OHFR_RTY_REQ_LO];
    end else if (wr_retry) begin
      phys_response_retry_max_q <= pwdata[`OHFR_RTY_PHYS_HI:`OHFR_RTY_PHYS_LO];
      dma_response_retry_max_q <= pwdata[`OHFR_RTY_RESP_HI:`OHFR_RTY_RESP_LO];
      dma_request_retry_max_q <= pwdata[`OHFR_RTY_REQ_HI:`OHFR_RTY_REQ_LO];
    end
  end

  assign phys_response_retry_max = phys_response_retry_max_q;
  assign dma_response_retry_max = dma_response_retry_max_q;
  assign dma_request_retry_max = dma_request_retry_max_q;

  // ----------------------------------------------------------------
  // compare and swap
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      swap_new_value_q <= `OHFR_WORD_RST;
      swap_expected_value_q <= `OHFR_WORD_RST;
      swap_target_select_q <= `OHFR_SWC_SEL_RST;
      swap_complete_q <= `OHFR_SWC_DONE_RST;
      swap_start_q <= 1'b0;
    end else begin
      if (swap_done) begin
        swap_new_value_q <= swap_old;
      end else if (wr_data) begin
        swap_new_value_q <= pwdata;
      end
      if (wr_cmp) begin
        swap_expected_value_q <= pwdata;
      end
      swap_start_q <= wr_ctrl;
      if (wr_ctrl) begin
        swap_target_select_q <= pwdata[`OHFR_SWC_SEL_HI:`OHFR_SWC_SEL_LO];
      end
      if (swap_done) begin
        swap_complete_q <= 1'b1;
      end else if (wr_ctrl) begin
        swap_complete_q <= 1'b0;
      end
    end
  end

  ohfr_csr_swap #(
    .BUS_MANAGER_ID_RST(BUS_MANAGER_ID_RST),
    .BANDWIDTH_RST(BANDWIDTH_RST),
    .CHANNELS_HI_RST(CHANNELS_HI_RST),
    .CHANNELS_LO_RST(CHANNELS_LO_RST)
  ) u_swap (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .host_req(swap_start_q),
    .host_sel(swap_target_select_q),
    .host_expected(swap_expected_value_q),
    .host_new(swap_new_value_q),
    .host_done(swap_done),
    .host_old(swap_old),
    .lnk_req(lnk_swap_req),
    .lnk_sel(lnk_swap_sel),
    .lnk_expected(lnk_swap_expected),
    .lnk_new(lnk_swap_new),
    .lnk_ack(lnk_swap_ack),
    .lnk_old(lnk_swap_old)
  );

endmodule

// ---- ohfr_rom_model.sv ----
`timescale 1ns/1ps

module ohfr_rom_model #(
  parameter [7:0] BOOT = 8'h40
) (
  input wire ref_clk,
  input wire rst_n,
  input wire present,
  input wire load_go,
  input wire [3:0] dly,
  input wire rom_fetch_req,
  input wire [7:0] rom_fetch_addr,
  output wire eeprom_present,
  output reg ver_load,
  output wire [7:0] ver_load_major,
  output wire [7:0] ver_load_minor,
  output wire [7:0] boot_image_start_in,
  output reg rom_fetch_ack,
  output wire [7:0] rom_fetch_data
);
  // ----------------------------------------
  // serial eeprom as seen by the loader
  // ----------------------------------------
  reg [3:0] cnt_q;
  reg ld_q;
  assign eeprom_present = present;
  assign boot_image_start_in = BOOT;
  // link options load beside it, outside this block
  assign ver_load_major = 8'h01;
  assign ver_load_minor = 8'h10;
  assign rom_fetch_data = rom_fetch_ack ? rom_fetch_addr ^ 8'h5a : ~(rom_fetch_addr ^ 8'h5a);
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      ld_q <= 1'b0;
      ver_load <= 1'b0;
      rom_fetch_ack <= 1'b0;
    end else begin
      ld_q <= load_go;
      ver_load <= load_go & ~ld_q;
      rom_fetch_ack <= 1'b0;
      if (!rom_fetch_req || rom_fetch_ack) begin
        cnt_q <= 4'h0;
      end else if (cnt_q == dly) begin
        rom_fetch_ack <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule

// ---- ohfr_front_regs_sva.sv ----
`timescale 1ns/1ps

module ohfr_front_regs_sva #(
  parameter ADDR_W = 8
) (
  input wire ref_clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire rom_fetch_req,
  input wire [7:0] rom_fetch_addr,
  input wire rom_fetch_ack,
  input wire [3:0] phys_response_retry_max,
  input wire [3:0] dma_response_retry_max,
  input wire [3:0] dma_request_retry_max,
  input wire lnk_swap_req,
  input wire lnk_swap_ack
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire acc = psel && penable;
  wire rd = acc && !pwrite;
  wire wr_rom = acc && pwrite && paddr == 8'h04;
  wire [11:0] rty = {phys_response_retry_max, dma_response_retry_max, dma_request_retry_max};

  property p_ack_drop; rom_fetch_ack |=> !rom_fetch_req; endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("req after ack");
  property p_req_hold;
    rom_fetch_req && !rom_fetch_ack |=> rom_fetch_req && $stable(rom_fetch_addr);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("req dropped");
  property p_step; rom_fetch_ack |=> rom_fetch_addr == $past(rom_fetch_addr) + 8'h01; endproperty
  a_step: assert property (p_step) else $error("pointer step");
  property p_go; wr_rom && pwdata[25] && !pwdata[31] && !rom_fetch_req |=> rom_fetch_req; endproperty
  a_go: assert property (p_go) else $error("go ignored");
  property p_clr; wr_rom && pwdata[31] && !rom_fetch_req |-> ##[1:2] rom_fetch_addr == 8'h00;
  endproperty
  a_clr: assert property (p_clr) else $error("pointer not cleared");
  property p_rty; acc && pwrite && paddr == 8'h08 |=> {20'h0, rty} == ($past(pwdata) & 32'hfff);
  endproperty
  a_rty: assert property (p_rty) else $error("retry outputs");
  property p_rom_rsv;
    rd && paddr == 8'h04 |-> prdata[30:26] == 5'h0 && !prdata[24] && prdata[15:8] == 8'h0;
  endproperty
  a_rom_rsv: assert property (p_rom_rsv) else $error("rom reserved");
  property p_rty_rsv; rd && paddr == 8'h08 |-> prdata[31:12] == 20'h0; endproperty
  a_rty_rsv: assert property (p_rty_rsv) else $error("retry reserved");
  property p_ctl_rsv; rd && paddr == 8'h14 |-> prdata[30:2] == 29'h0; endproperty
  a_ctl_rsv: assert property (p_ctl_rsv) else $error("control reserved");
  property p_lnk; $rose(lnk_swap_req) |-> ##[1:3] lnk_swap_ack; endproperty
  a_lnk: assert property (p_lnk) else $error("link swap no ack");

  c_fetch: cover property (rom_fetch_ack);
  c_lnk: cover property (lnk_swap_ack);
  c_done: cover property (rd && paddr == 8'h14 && prdata[31]);
endmodule

// ---- ohfr_front_regs_tb.sv ----
`timescale 1ns/1ps

module ohfr_front_regs_tb;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} ohfr_row_t;
  logic ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic present = 1'b1, load_go = 1'b0, lnk_req = 1'b0;
  logic pready, pslverr, rerr, e_pres, v_ld, rom_req, rom_ack, lnk_ack;
  logic [1:0] lnk_sel = 2'h0;
  logic [3:0] dly = 4'h0;
  logic [3:0] phys_max, resp_max, req_max;
  logic [7:0] paddr = 8'h00;
  logic [7:0] v_maj, v_min, boot, rom_addr, rom_data;
  logic [31:0] pwdata = 32'h0, lnk_exp = 32'h0, lnk_new = 32'h0;
  logic [31:0] prdata, rdata, nv, lnk_old;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  int n;
  logic [31:0] rst_v [4] = '{32'h3f, 32'h1333, 32'hffffffff, 32'hffffffff};
  ohfr_row_t rows [12] = '{
    '{1'b0, 8'h00, 32'h0, 32'h01010000},
    '{1'b0, 8'h04, 32'h0, 32'h00000040},
    '{1'b0, 8'h08, 32'h0, 32'h0}, '{1'b1, 8'h08, 32'hffffffff, 32'h0},
    '{1'b0, 8'h08, 32'h0, 32'h00000fff},
    '{1'b0, 8'h14, 32'h0, 32'h80000000}, '{1'b1, 8'h00, 32'hffffffff, 32'h0},
    '{1'b0, 8'h00, 32'h0, 32'h01010000},
    '{1'b1, 8'h10, 32'ha5a5a5a5, 32'h0}, '{1'b0, 8'h10, 32'h0, 32'ha5a5a5a5},
    '{1'b1, 8'h0c, 32'h5a5a5a5a, 32'h0}, '{1'b0, 8'h0c, 32'h0, 32'h5a5a5a5a}
  };

  ohfr_front_regs dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .eeprom_present(e_pres), .ver_load(v_ld), .ver_load_major(v_maj),
    .ver_load_minor(v_min), .boot_image_start_in(boot), .rom_fetch_req(rom_req),
    .rom_fetch_addr(rom_addr), .rom_fetch_ack(rom_ack), .rom_fetch_data(rom_data),
    .phys_response_retry_max(phys_max), .dma_response_retry_max(resp_max),
    .dma_request_retry_max(req_max), .lnk_swap_req(lnk_req), .lnk_swap_sel(lnk_sel),
    .lnk_swap_expected(lnk_exp), .lnk_swap_new(lnk_new), .lnk_swap_ack(lnk_ack),
    .lnk_swap_old(lnk_old)
  );
  ohfr_rom_model u_rom (
    .ref_clk(ref_clk), .rst_n(rst_n), .present(present), .load_go(load_go), .dly(dly),
    .rom_fetch_req(rom_req), .rom_fetch_addr(rom_addr), .eeprom_present(e_pres),
    .ver_load(v_ld), .ver_load_major(v_maj), .ver_load_minor(v_min),
    .boot_image_start_in(boot), .rom_fetch_ack(rom_ack), .rom_fetch_data(rom_data)
  );

  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      end_sim;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while (rdata[b] !== v && n < 40);
    chk({31'h0, rdata[b]}, {31'h0, v});
  endtask
  task automatic end_sim;
    $display("comparisons %0d failures %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(rdata, rows[i].e);
    end
    apb(1'b0, 8'h18, 32'h0);
    chk({rdata[30:0], rerr}, 32'h00000001);
    $display("test table done");
    apb(1'b1, 8'h04, 32'h02000000);
    poll(8'h04, 25, 1'b0);
    chk(rdata, 32'h005a0040);
    dly <= 4'h6;
    apb(1'b1, 8'h04, 32'h02000000);
    poll(8'h04, 25, 1'b0);
    chk(rdata, 32'h005b0040);
    apb(1'b1, 8'h04, 32'h82000000);
    poll(8'h04, 25, 1'b0);
    chk(rdata, 32'h005a0040);
    $display("test rom done");
    for (int s = 0; s < 4; s++) begin
      nv = 32'h0bad0000 | s;
      apb(1'b1, 8'h0c, nv);
      apb(1'b1, 8'h10, rst_v[s]);
      apb(1'b1, 8'h14, 32'h7ffffffc | s);
      rd(8'h14, s);
      poll(8'h14, 31, 1'b1);
      chk(rdata, 32'h80000000 | s);
      rd(8'h0c, rst_v[s]);
      apb(1'b1, 8'h0c, 32'h0);
      apb(1'b1, 8'h14, s);
      poll(8'h14, 31, 1'b1);
      rd(8'h0c, nv);
      lnk_sel <= s[1:0];
      lnk_exp <= nv;
      lnk_new <= ~nv;
      lnk_req <= 1'b1;
      @(posedge ref_clk);
      lnk_req <= 1'b0;
      n = 0;
      while (lnk_ack !== 1'b1 && n < 4) begin
        @(posedge ref_clk);
        n++;
      end
      chk(lnk_old, nv);
      @(posedge ref_clk);
    end
    $display("test swap done");
    load_go <= 1'b1;
    repeat (3) @(posedge ref_clk);
    load_go <= 1'b0;
    rd(8'h00, 32'h01010010);
    present <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rd(8'h00, 32'h00010010);
    rd(8'h04, 32'h005a0000);
    $display("test load done");
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(8'h00, 32'h00010000);
    rd(8'h14, 32'h80000000);
    rd(8'h08, 32'h0);
    $display("test reset done");
    end_sim;
  end
endmodule

bind ohfr_front_regs ohfr_front_regs_sva #(.ADDR_W(ADDR_W)) u_sva (
  .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .rom_fetch_req(rom_fetch_req),
  .rom_fetch_addr(rom_fetch_addr), .rom_fetch_ack(rom_fetch_ack),
  .phys_response_retry_max(phys_response_retry_max),
  .dma_response_retry_max(dma_response_retry_max),
  .dma_request_retry_max(dma_request_retry_max),
  .lnk_swap_req(lnk_swap_req), .lnk_swap_ack(lnk_swap_ack)
);
